//--- hw/cxe_pkg.sv
// Package: constants and types of the exception and edge-detect unit
package cxe_pkg;
  localparam int          NPIN            = 4;
  localparam logic [1:0]  ADDR_RISE       = 2'h0;
  localparam logic [1:0]  ADDR_FALL       = 2'h1;
  localparam logic [1:0]  ADDR_STAT       = 2'h2;
  localparam logic [1:0]  ADDR_CAUSE      = 2'h3;
  localparam logic [7:0]  SEL_RESET       = 8'h00;
  localparam logic [31:0] STATUS_RESET    = 32'h00000020;
  localparam int          BIT_ID          = 5;
  localparam int          BIT_EP          = 6;
  localparam int          BIT_NP          = 7;
  localparam logic [31:0] VEC_TRAP_LO     = 32'h00000040;
  localparam logic [31:0] VEC_TRAP_HI     = 32'h00000050;
  localparam logic [31:0] VEC_DEBUG       = 32'h00000060;
  localparam logic [15:0] CODE_TRAP_BASE  = 16'h0040;
  localparam logic [5:0]  ILG_OPC         = 6'h3F;
  localparam logic [3:0]  ILG_SUB_MIN     = 4'h7;
  localparam int          ACK_MIN_CLK     = 4;
  localparam int          ACK_MAX_CLK     = 6;
  localparam logic [2:0]  ACK_CNT_INIT    = 3'h3;

  typedef enum logic [2:0]
  {
    CXE_OP_NONE   = 3'b000,
    CXE_OP_TRAP   = 3'b001,
    CXE_OP_EXCEPTION_RETURN_INSTR   = 3'b010,
    CXE_OP_DBTRP  = 3'b011,
    CXE_OP_DEBUG_RETURN_INSTR  = 3'b100,
    CXE_OP_INSTR  = 3'b101
  } cxe_op_e;

  typedef struct packed
  {
    cxe_op_e     op;
    logic [31:0] word;
    logic [31:0] ret_pc;
    logic        no_sample;
  } cxe_instr_s;

  typedef struct packed
  {
    logic        load;
    logic [31:0] pc;
  } cxe_redirect_s;
endpackage

//--- hw/cxe_core.sv
// Module: exception entry/return sequencing and external edge detection
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE1: each external pin has its own valid edge choice
// RULE2: after reset no edge detection, no request, NMI pin plain port
// RULE3: falling/rising bit pair decodes none, rising, falling, both
// RULE4: bit 0 controls NMI pin, bits 1 to 3 the maskable pins
// RULE5: two 8-bit select registers, read/write, reset to zero
// RULE6: software clears select bits before switching a pin to port use
// RULE7: trap always accepted, saves PC and status, code, sets EP and ID
// RULE8: trap vector ranges 00H to 1FH
// RULE9: trap handler 40H for vectors 00H-0FH, 50H for 10H-1FH
// RULE10: exception return with EP set restores PC and status
// RULE11: EP is status bit 6, set on every exception
// RULE12: illegal opcode pattern raises an exception trap
// RULE13: exception trap saves to debug registers, sets NP EP ID, jumps 60H
// RULE14: debug trap always accepted, same sequence, handler 60H
// RULE15: debug return restores PC and status from debug saves
// RULE16: request to handler takes 4 to 6 system clocks
// RULE17: latency may exceed bound after back-to-back non-sample instructions
// RULE18: no acceptance right after a sampling-suppressing instruction
// RULE19: NMI and exceptions accepted regardless of interrupt disable
// RULE20: pins sampled each clock, matching change gives one-cycle request
module cxe_core
  import cxe_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic [1:0]    addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [31:0]   rdata,
  input  wire logic [NPIN-1:0] pin_in,
  input  wire cxe_instr_s    instr,
  input  wire logic          maskable_req,
  output logic      [NPIN-1:0] edge_req,
  output cxe_redirect_s      redirect,
  output logic               irq_ack,
  output logic      [31:0]   status_word,
  output logic      [31:0]   exception_pc_save,
  output logic      [31:0]   exception_status_save,
  output logic      [31:0]   exception_cause_reg,
  output logic      [31:0]   debug_pc_save,
  output logic      [31:0]   debug_status_save
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------
  // Edge select registers
  // ----------------------------------------
  logic [7:0] rising_edge_select;
  logic [7:0] falling_edge_select;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rising_edge_select  <= SEL_RESET; // [RULE2] [RULE5]
      falling_edge_select <= SEL_RESET; // [RULE2] [RULE5]
    end
    else if (wr && addr == ADDR_RISE)
      rising_edge_select  <= wdata[7:0]; // [RULE5]
    else if (wr && addr == ADDR_FALL)
      falling_edge_select <= wdata[7:0]; // [RULE5]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 32'h00000000;
    else if (rd)
    begin
      unique case (addr)
        ADDR_RISE:  rdata <= {24'h000000, rising_edge_select};
        ADDR_FALL:  rdata <= {24'h000000, falling_edge_select};
        ADDR_STAT:  rdata <= status_word;
        ADDR_CAUSE: rdata <= exception_cause_reg;
      endcase
    end
    else
      rdata <= 32'h00000000;
  end

  // ----------------------------------------
  // Edge detector
  // ----------------------------------------
  logic [NPIN-1:0] pin_prev;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_prev <= '0;
    else
      pin_prev <= pin_in; // [RULE20]
  end

  for (genvar n = 0; n < NPIN; n++)
  begin : g_edge
    logic hit;
    // Bit n of each select register drives pin n, bit 0 is NMI
    assign hit = (rising_edge_select[n]  &  pin_in[n] & ~pin_prev[n])
               | (falling_edge_select[n] & ~pin_in[n] &  pin_prev[n]); // [RULE1] [RULE3] [RULE4]
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        edge_req[n] <= 1'b0;
      else
        edge_req[n] <= hit; // [RULE20]
    end
  end

  // ----------------------------------------
  // Illegal opcode decode
  // ----------------------------------------
  logic illegal;
  assign illegal = instr.op == CXE_OP_INSTR && instr.word[10:5] == ILG_OPC
                 && instr.word[26:23] >= ILG_SUB_MIN && !instr.word[16]; // [RULE12]

  // ----------------------------------------
  // Interrupt acknowledge timing
  // ----------------------------------------
  logic       nmi_pend;
  logic       mi_pend;
  logic       hold;
  logic [2:0] ack_cnt;
  logic       acking;
  logic       ack_nmi;
  logic       can_sample;
  assign can_sample = !hold && !instr.no_sample; // [RULE18] [RULE17]

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold <= 1'b0;
    else
      hold <= instr.no_sample; // [RULE18]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nmi_pend <= 1'b0;
      mi_pend  <= 1'b0;
    end
    else
    begin
      if (edge_req[0])
        nmi_pend <= 1'b1;
      else if (acking && ack_cnt == 3'h0 && ack_nmi)
        nmi_pend <= 1'b0;
      if (maskable_req || |edge_req[NPIN-1:1])
        mi_pend <= 1'b1;
      else if (acking && ack_cnt == 3'h0 && !ack_nmi)
        mi_pend <= 1'b0;
    end
  end

  // Acknowledge sequence: request, then INT1..INT4, then handler
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acking  <= 1'b0;
      ack_cnt <= 3'h0;
      ack_nmi <= 1'b0;
    end
    else if (!acking)
    begin
      if (can_sample && (nmi_pend || (mi_pend && !status_word[BIT_ID]))) // [RULE19]
      begin
        acking  <= 1'b1;
        ack_cnt <= ACK_CNT_INIT; // [RULE16]
        ack_nmi <= nmi_pend;
      end
    end
    else if (ack_cnt == 3'h0)
      acking <= 1'b0;
    else
      ack_cnt <= ack_cnt - 3'h1; // [RULE16]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_ack <= 1'b0;
    else
      irq_ack <= acking && ack_cnt == 3'h0; // [RULE16]
  end

  // ----------------------------------------
  // Exception entry and return
  // ----------------------------------------
  logic [31:0] trap_vec;
  assign trap_vec = instr.word[4] ? VEC_TRAP_HI : VEC_TRAP_LO; // [RULE8] [RULE9]

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_word           <= STATUS_RESET;
      exception_pc_save     <= 32'h00000000;
      exception_status_save <= 32'h00000000;
      exception_cause_reg   <= 32'h00000000;
      debug_pc_save         <= 32'h00000000;
      debug_status_save     <= 32'h00000000;
      redirect              <= '0;
    end
    else
    begin
      redirect.load <= 1'b0;
      unique case (instr.op)
        CXE_OP_TRAP:
        begin
          exception_pc_save     <= instr.ret_pc; // [RULE7]
          exception_status_save <= status_word; // [RULE7]
          exception_cause_reg[15:0] <= CODE_TRAP_BASE | {11'h000, instr.word[4:0]}; // [RULE7]
          status_word[BIT_EP]   <= 1'b1; // [RULE11]
          status_word[BIT_ID]   <= 1'b1; // [RULE7]
          redirect              <= '{load: 1'b1, pc: trap_vec}; // [RULE9]
        end
        CXE_OP_EXCEPTION_RETURN_INSTR:
        begin
          if (status_word[BIT_EP])
          begin
            status_word <= exception_status_save; // [RULE10]
            redirect    <= '{load: 1'b1, pc: exception_pc_save}; // [RULE10]
          end
        end
        CXE_OP_DBTRP, CXE_OP_INSTR:
        begin
          if (instr.op == CXE_OP_DBTRP || illegal)
          begin
            debug_pc_save       <= instr.ret_pc; // [RULE13] [RULE14]
            debug_status_save   <= status_word; // [RULE13] [RULE14]
            status_word[BIT_NP] <= 1'b1; // [RULE13]
            status_word[BIT_EP] <= 1'b1; // [RULE11] [RULE13]
            status_word[BIT_ID] <= 1'b1; // [RULE13]
            redirect            <= '{load: 1'b1, pc: VEC_DEBUG}; // [RULE13] [RULE14]
          end
        end
        CXE_OP_DEBUG_RETURN_INSTR:
        begin
          status_word <= debug_status_save; // [RULE15]
          redirect    <= '{load: 1'b1, pc: debug_pc_save}; // [RULE15]
        end
        CXE_OP_NONE:
        begin
          if (wr && addr == ADDR_STAT)
            status_word <= wdata;
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_edge_rise;
    @(posedge ref_clk) disable iff (!rst_n)
      (rising_edge_select[1] && pin_in[1] && !pin_prev[1]) |=> edge_req[1];
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed"); // [RULE3]

  property p_edge_none;
    @(posedge ref_clk) disable iff (!rst_n)
      (rising_edge_select[NPIN-1:0] == '0 && falling_edge_select[NPIN-1:0] == '0)
        |=> edge_req == '0;
  endproperty
  a_edge_none: assert property (p_edge_none) else $error("request with no edge set"); // [RULE2]

  property p_edge_fall;
    @(posedge ref_clk) disable iff (!rst_n)
      (falling_edge_select[0] && !pin_in[0] && pin_prev[0]) |=> edge_req[0];
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed"); // [RULE4]

  property p_trap_vec;
    @(posedge ref_clk) disable iff (!rst_n)
      (instr.op == CXE_OP_TRAP) |=> redirect.load
        && redirect.pc == ($past(instr.word[4]) ? VEC_TRAP_HI : VEC_TRAP_LO);
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap handler wrong"); // [RULE9]

  property p_trap_flags;
    @(posedge ref_clk) disable iff (!rst_n)
      (instr.op == CXE_OP_TRAP) |=> status_word[BIT_EP] && status_word[BIT_ID]
        && exception_status_save == $past(status_word);
  endproperty
  a_trap_flags: assert property (p_trap_flags) else $error("trap entry wrong"); // [RULE7]

  property p_illegal;
    @(posedge ref_clk) disable iff (!rst_n)
      illegal |=> redirect.pc == VEC_DEBUG && status_word[BIT_NP] && status_word[BIT_EP];
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal trap wrong"); // [RULE13]

  property p_debug_return_instr;
    @(posedge ref_clk) disable iff (!rst_n)
      (instr.op == CXE_OP_DEBUG_RETURN_INSTR) |=> redirect.pc == $past(debug_pc_save)
        && status_word == $past(debug_status_save);
  endproperty
  a_debug_return_instr: assert property (p_debug_return_instr) else $error("debug return wrong"); // [RULE15]

  sequence s_nmi_start;
    !acking && can_sample && nmi_pend;
  endsequence
  property p_latency;
    @(posedge ref_clk) disable iff (!rst_n)
      s_nmi_start |=> !irq_ack [*4] ##1 irq_ack;
  endproperty
  a_latency: assert property (p_latency) else $error("ack timing wrong"); // [RULE16]

  property p_nosample;
    @(posedge ref_clk) disable iff (!rst_n)
      (!acking && instr.no_sample) |=> !acking;
  endproperty
  a_nosample: assert property (p_nosample) else $error("ack after non-sample"); // [RULE18]

  property p_exception_return_instr_ignore;
    @(posedge ref_clk) disable iff (!rst_n)
      (instr.op == CXE_OP_EXCEPTION_RETURN_INSTR && !status_word[BIT_EP]) |=> !redirect.load && $stable(status_word);
  endproperty
  a_exception_return_instr_ignore: assert property (p_exception_return_instr_ignore) else $error("return taken without EP"); // [RULE10]

  property p_exception_return_instr;
    @(posedge ref_clk) disable iff (!rst_n)
      (instr.op == CXE_OP_EXCEPTION_RETURN_INSTR && status_word[BIT_EP]) |=> redirect.load
        && redirect.pc == $past(exception_pc_save) && status_word == $past(exception_status_save);
  endproperty
  a_exception_return_instr: assert property (p_exception_return_instr) else $error("exception return wrong"); // [RULE10]

  property p_debug_break_instr;
    @(posedge ref_clk) disable iff (!rst_n)
      (instr.op == CXE_OP_DBTRP) |=> redirect.load && redirect.pc == VEC_DEBUG
        && debug_pc_save == $past(instr.ret_pc) && status_word[BIT_NP];
  endproperty
  a_debug_break_instr: assert property (p_debug_break_instr) else $error("debug trap entry wrong"); // [RULE14]

  property p_masked;
    @(posedge ref_clk) disable iff (!rst_n)
      (!acking && !nmi_pend && status_word[BIT_ID]) |=> !acking;
  endproperty
  a_masked: assert property (p_masked) else $error("maskable ack while disabled"); // [RULE19]

  property p_sel_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && addr == ADDR_RISE) |=> rising_edge_select == $past(wdata[7:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost"); // [RULE5]

  property p_rd_data;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_FALL) |=> rdata == {24'h000000, $past(falling_edge_select)};
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("select read wrong"); // [RULE5]
endmodule
`default_nettype wire

//--- dv/cxe_partner.sv
// Partner model: external pin levels and executed instruction stream
`timescale 1ns/10ps
`default_nettype none
module cxe_partner
  import cxe_pkg::*;
(
  input  wire logic            ref_clk,
  output var  logic [NPIN-1:0] pin_in,
  output var  cxe_instr_s      instr
);
  // ----------------------------------------
  // Idle state
  // ----------------------------------------
  initial
  begin
    pin_in = '0;
    instr  = '{CXE_OP_NONE, 32'h0, 32'h0, 1'b0};
  end

  // ----------------------------------------
  // Stimulus tasks
  // ----------------------------------------
  // Pin level change at next edge
  task automatic set_pin(input int n, input logic v);
    @(posedge ref_clk);
    pin_in[n] <= v;
  endtask

  // One instruction, then idle with changed payload
  task automatic exec(input cxe_op_e op, input logic [31:0] w, input logic [31:0] rpc);
    @(posedge ref_clk);
    instr <= '{op, w, rpc, 1'b0};
    @(posedge ref_clk);
    instr <= '{CXE_OP_NONE, ~w, ~rpc, 1'b0};
    #1;
  endtask

  // Back-to-back sampling-suppressing instructions from current edge
  task automatic run_ns(input int n);
    for (int i = 0; i < n; i++)
    begin
      instr <= '{CXE_OP_INSTR, 32'h0, 32'h0, 1'b1};
      @(posedge ref_clk);
    end
    instr <= '{CXE_OP_NONE, 32'h0, 32'h0, 1'b0};
  endtask
endmodule
`default_nettype wire

//--- dv/cpu_exception_and_edge_detect_test.sv
// Testbench: exception and edge-detect unit
`timescale 1ns/10ps
`default_nettype none
module cpu_exception_and_edge_detect_test
  import cxe_pkg::*;
;
  logic            ref_clk;
  logic            arst_n;
  logic [1:0]      addr;
  logic [31:0]     wdata;
  logic            wr;
  logic            rd;
  logic            maskable_req;
  logic [31:0]     rdata;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] edge_req;
  cxe_instr_s      instr;
  cxe_redirect_s   redirect;
  logic            irq_ack;
  logic [31:0]     status_word;
  logic [31:0]     epc;
  logic [31:0]     eps;
  logic [31:0]     cause;
  logic [31:0]     dpc;
  logic [31:0]     dps;
  int              err_total;
  int              checks_done;
  int              k;

  cxe_core u_cxe_core (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .instr(instr),
    .maskable_req(maskable_req), .edge_req(edge_req), .redirect(redirect),
    .irq_ack(irq_ack), .status_word(status_word), .exception_pc_save(epc),
    .exception_status_save(eps), .exception_cause_reg(cause),
    .debug_pc_save(dpc), .debug_status_save(dps));

  cxe_partner u_cxe_partner (.ref_clk(ref_clk), .pin_in(pin_in), .instr(instr));

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask

  task automatic bus_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic count(input int n, output logic [31:0] c);
    c = 0;
    repeat (5)
    begin
      @(posedge ref_clk);
      #1;
      if (edge_req[n] === 1'b1)
        c = c + 1;
    end
  endtask

  task automatic run(input cxe_op_e op, input logic [31:0] w, input logic [31:0] rpc,
                     input logic ld, input logic [31:0] pc, input logic [31:0] st);
    u_cxe_partner.exec(op, w, rpc);
    chk("load", 32'(redirect.load), 32'(ld));
    if (ld)
      chk("pc", redirect.pc, pc);
    chk("status", status_word, st);
  endtask

  task automatic lat(input int ns, output int n);
    @(posedge ref_clk);
    maskable_req <= 1'b1;
    fork
      u_cxe_partner.run_ns(ns);
      begin
        n = 0;
        while (irq_ack !== 1'b1 && n < 20)
        begin
          @(posedge ref_clk);
          #1;
          n++;
        end
      end
    join
    @(posedge ref_clk);
    maskable_req <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values();
    logic [31:0] d;
    bus_rd(ADDR_RISE, d);
    chk("rise_rst", d, 32'h0);
    bus_rd(ADDR_FALL, d);
    chk("fall_rst", d, 32'h0);
    bus_rd(ADDR_STAT, d);
    chk("stat_rst", d, STATUS_RESET);
    bus_wr(ADDR_RISE, 32'hFF);
    bus_rd(ADDR_RISE, d);
    chk("rise_rw", d, 32'hFF);
  endtask

  task automatic edges();
    logic [31:0] d;
    logic [31:0] c;
    for (int n = 0; n < NPIN; n++)
      for (int m = 0; m < 4; m++)
      begin
        bus_wr(ADDR_RISE, 32'(m[0]) << n);
        bus_wr(ADDR_FALL, 32'(m[1]) << n);
        bus_rd(ADDR_FALL, d);
        chk("fall_sel", d, 32'(m[1]) << n);
        u_cxe_partner.set_pin(n, 1'b1);
        count(n, c);
        chk("rise_req", c, 32'(m[0]));
        u_cxe_partner.set_pin(n, 1'b0);
        count(n, c);
        chk("fall_req", c, 32'(m[1]));
      end
    bus_wr(ADDR_RISE, 32'h0);
    bus_wr(ADDR_FALL, 32'h0);
  endtask

  task automatic traps();
    logic [31:0] d;
    run(CXE_OP_TRAP, 32'h0F, 32'h1234, 1'b1, VEC_TRAP_LO, 32'h60);
    chk("epc", epc, 32'h1234);
    chk("eps", eps, 32'h20);
    chk("cause", {16'h0, cause[15:0]}, 32'h4F);
    bus_rd(ADDR_CAUSE, d);
    chk("cause_rd", d, 32'h4F);
    run(CXE_OP_EXCEPTION_RETURN_INSTR, 32'h0, 32'h0, 1'b1, 32'h1234, 32'h20);
    run(CXE_OP_EXCEPTION_RETURN_INSTR, 32'h0, 32'h0, 1'b0, 32'h0, 32'h20);
    run(CXE_OP_TRAP, 32'h10, 32'h2000, 1'b1, VEC_TRAP_HI, 32'h60);
    chk("cause", {16'h0, cause[15:0]}, 32'h50);
    run(CXE_OP_EXCEPTION_RETURN_INSTR, 32'h0, 32'h0, 1'b1, 32'h2000, 32'h20);
  endtask

  task automatic debug_traps();
    run(CXE_OP_INSTR, 32'h030007E0, 32'h300, 1'b0, 32'h0, 32'h20);
    run(CXE_OP_INSTR, 32'h038107E0, 32'h300, 1'b0, 32'h0, 32'h20);
    run(CXE_OP_INSTR, 32'h038007E0, 32'h300, 1'b1, VEC_DEBUG, 32'hE0);
    chk("dpc", dpc, 32'h300);
    chk("dps", dps, 32'h20);
    run(CXE_OP_DEBUG_RETURN_INSTR, 32'h0, 32'h0, 1'b1, 32'h300, 32'h20);
    run(CXE_OP_DBTRP, 32'h0, 32'h400, 1'b1, VEC_DEBUG, 32'hE0);
    chk("dpc", dpc, 32'h400);
    run(CXE_OP_DEBUG_RETURN_INSTR, 32'h0, 32'h0, 1'b1, 32'h400, 32'h20);
  endtask

  task automatic latency();
    bus_wr(ADDR_STAT, 32'h0);
    // Drain requests left pending by the edge scenario
    repeat (10) @(posedge ref_clk);
    lat(0, k);
    chk("ack_lat", 32'(k >= ACK_MIN_CLK && k <= ACK_MAX_CLK), 32'h1);
    bus_wr(ADDR_STAT, 32'h0);
    lat(3, k);
    chk("ack_held", 32'(k > ACK_MAX_CLK && k < 20), 32'h1);
    bus_wr(ADDR_STAT, 32'h20);
    lat(0, k);
    chk("ack_masked", 32'(k), 32'd20);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    ref_clk      = 1'b0;
    arst_n       = 1'b0;
    addr         = 2'h0;
    wdata        = 32'h0;
    wr           = 1'b0;
    rd           = 1'b0;
    maskable_req = 1'b0;
    err_total    = 0;
    checks_done  = 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset_values();
    edges();
    traps();
    debug_traps();
    latency();
    tally_and_finish();
  end

  initial
  begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
